// >>> logic/drscu_consts.vh
// Constants for the dual resistor serial command unit.
// Assumes inclusion by the single design file; definitions only.
`ifndef DRSCU_CONSTS_VH
`define DRSCU_CONSTS_VH
// ****************************************
// Word layout
// ****************************************
`define DRSCU_WORD_BITS 24
`define DRSCU_CMD_MSB 23
`define DRSCU_CMD_LSB 20
`define DRSCU_ADR_MSB 19
`define DRSCU_ADR_LSB 16
`define DRSCU_WIPER_BITS 10
// ****************************************
// Command codes
// ****************************************
`define DRSCU_CMD_NOP 4'h0
`define DRSCU_CMD_RESTORE 4'h1
`define DRSCU_CMD_STORE_WIPER 4'h2
`define DRSCU_CMD_STORE_ANY 4'h3
`define DRSCU_CMD_DEC6 4'h4
`define DRSCU_CMD_DEC6_ALL 4'h5
`define DRSCU_CMD_DEC1 4'h6
`define DRSCU_CMD_DEC1_ALL 4'h7
`define DRSCU_CMD_RESTORE_ALL 4'h8
`define DRSCU_CMD_READ_NV 4'h9
`define DRSCU_CMD_READ_WIPER 4'hA
`define DRSCU_CMD_WRITE_WIPER 4'hB
`define DRSCU_CMD_INC6 4'hC
`define DRSCU_CMD_INC6_ALL 4'hD
`define DRSCU_CMD_INC1 4'hE
`define DRSCU_CMD_INC1_ALL 4'hF
// ****************************************
// Values and timing
// ****************************************
`define DRSCU_MIDSCALE 10'h200
`define DRSCU_WIPER_MAX 10'h3FF
`define DRSCU_USER_LO 4'h2
`define DRSCU_USER_HI 4'hE
`define DRSCU_STORE_MS 15
`define DRSCU_CLK_HZ 40000000
`define DRSCU_STORE_CYC (`DRSCU_STORE_MS * (`DRSCU_CLK_HZ / 1000))
// ****************************************
// Register offsets
// ****************************************
`define DRSCU_REG_WIPER0 8'h00
`define DRSCU_REG_WIPER1 8'h04
`define DRSCU_REG_STATUS 8'h08
`define DRSCU_REG_CTRL 8'h0C
`endif

// >>> logic/drscu_top.v
// Serial command logic of a dual digital resistor with nonvolatile store.
// Assumes serial pins arrive asynchronously and are sampled by aclk,
// and that the host registers (AXI4-Lite) mirror the wipers and busy state.
//
// The address map and the AXI4-Lite slave port were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "drscu_consts.vh"
module drscu_top #(
    parameter STORE_CYCLES = `DRSCU_STORE_CYC
)
(
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // AXI4-Lite write channels
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    output reg [1:0] s_axi_bresp,
    // AXI4-Lite read channels
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    input wire [7:0] s_axi_araddr,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    // Serial link pins
    input wire serial_clk,
    input wire chip_select_n,
    input wire serial_in,
    output reg serial_out,
    output reg serial_out_oe,
    // Control pins
    input wire preset_strobe_n,
    input wire write_protect_n,
    output reg ready_oe,
    // Wiper setting registers
    output reg [9:0] wiper0_r,
    output reg [9:0] wiper1_r
);
    // ****************************************
    // Register map
    // ****************************************
    localparam [7:0] REG_WIPER0 = `DRSCU_REG_WIPER0;
    localparam [7:0] REG_WIPER1 = `DRSCU_REG_WIPER1;
    localparam [7:0] REG_STATUS = `DRSCU_REG_STATUS;
    localparam [7:0] REG_CTRL = `DRSCU_REG_CTRL;
    localparam [31:0] STORE_N = STORE_CYCLES;

    // Synchronisers: first stage read by second only
    reg [4:0] sync1_r;
    reg [4:0] sync2_r;
    reg sclk_d_r;
    reg cs_d_r;
    reg pr_d_r;
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sync1_r <= 5'h1F;
            sync2_r <= 5'h1F;
            sclk_d_r <= 1'b1;
            cs_d_r <= 1'b1;
            pr_d_r <= 1'b1;
        end
        else
        begin
            sync1_r <= {write_protect_n, preset_strobe_n, serial_in, chip_select_n, serial_clk};
            sync2_r <= sync1_r;
            sclk_d_r <= sync2_r[0];
            cs_d_r <= sync2_r[1];
            pr_d_r <= sync2_r[3];
        end
    end
    wire sclk_s = sync2_r[0];
    wire cs_s = sync2_r[1];
    wire sdi_s = sync2_r[2];
    wire pr_s = sync2_r[3];
    wire wp_s = sync2_r[4];
    wire sclk_rise = sclk_s && !sclk_d_r;
    wire sclk_fall = !sclk_s && sclk_d_r;
    wire cs_rise = cs_s && !cs_d_r;
    wire pr_rise = pr_s && !pr_d_r;

    // ****************************************
    // Serial shift and command state
    // ****************************************
    reg [23:0] shift_r;
    reg [23:0] out_r;
    reg [5:0] bitcnt_r;
    reg [31:0] busy_cnt_r;
    reg busy_r;
    reg [15:0] nv_r [0:15];
    reg [15:0] nv_nxt;
    reg [9:0] w_nxt;
    reg sw_lock_r;
    reg booted_r;
    reg [23:0] last_r;
    reg have_last_r;
    reg exec_r;
    integer i;

    wire [3:0] cmd = last_r[`DRSCU_CMD_MSB:`DRSCU_CMD_LSB];
    wire [3:0] adr = last_r[`DRSCU_ADR_MSB:`DRSCU_ADR_LSB];
    wire ch = adr[0];
    wire [9:0] wdat = last_r[9:0];
    wire [9:0] wsel = ch ? wiper1_r : wiper0_r;
    wire wr_ok = wp_s && !sw_lock_r; // Pin or software lock blocks changes
    wire word_end = cs_rise && !busy_r && (bitcnt_r[1:0] == 2'b00);

    // Saturating adjust helper
    function [9:0] adj;
        input [9:0] v;
        input [1:0] op;
        begin
            case (op)
                2'h0: adj = v >> 1;
                2'h1: adj = (v[9]) ? `DRSCU_WIPER_MAX : {v[8:0], 1'b0};
                2'h2: adj = (v == 10'h000) ? 10'h000 : v - 10'h001;
                default: adj = (v == `DRSCU_WIPER_MAX) ? v : v + 10'h001;
            endcase
        end
    endfunction

    // Shift in, execute on chip select rise, and timed store lockout
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            shift_r <= 24'h000000;
            out_r <= 24'h000000;
            bitcnt_r <= 6'h00;
            busy_r <= 1'b0;
            busy_cnt_r <= 32'h00000000;
            wiper0_r <= `DRSCU_MIDSCALE;
            wiper1_r <= `DRSCU_MIDSCALE;
            booted_r <= 1'b0;
            last_r <= 24'h000000;
            have_last_r <= 1'b0;
            ready_oe <= 1'b0;
            serial_out <= 1'b1;
            serial_out_oe <= 1'b0;
            for (i = 0; i < 16; i = i + 1)
                nv_r[i] <= {6'h00, `DRSCU_MIDSCALE};
        end
        else
        begin
            // Power-on reload from the store, once
            if (!booted_r)
            begin
                booted_r <= 1'b1;
                wiper0_r <= nv_r[0][9:0];
                wiper1_r <= nv_r[1][9:0];
            end
            // Store timer; ready low until it expires
            if (busy_r)
            begin
                ready_oe <= 1'b1;
                if (busy_cnt_r >= STORE_N - 32'h1)
                begin
                    busy_r <= 1'b0;
                    ready_oe <= 1'b0;
                end
                else
                    busy_cnt_r <= busy_cnt_r + 32'h1;
            end
            // Shift capture; locked while storing
            if (!cs_s && !busy_r && sclk_rise)
            begin
                shift_r <= {shift_r[22:0], sdi_s};
                bitcnt_r <= (bitcnt_r == 6'h2F) ? 6'h18 : bitcnt_r + 6'h01;
            end
            // Output bits change on falling serial edge
            serial_out_oe <= !cs_s && !out_r[23];
            serial_out <= out_r[23];
            if (!cs_s && sclk_fall)
                out_r <= {out_r[22:0], 1'b1};
            // Preset: low holds midscale, rise reloads
            if (!pr_s)
            begin
                wiper0_r <= `DRSCU_MIDSCALE;
                wiper1_r <= `DRSCU_MIDSCALE;
            end
            else if (pr_rise)
            begin
                wiper0_r <= nv_r[0][9:0];
                wiper1_r <= nv_r[1][9:0];
            end
            // Frame ends: latch word, or drop a misaligned count
            if (cs_rise && !busy_r)
            begin
                bitcnt_r <= 6'h00;
                if (bitcnt_r != 6'h00 && bitcnt_r[1:0] == 2'b00)
                begin
                    last_r <= shift_r;
                    have_last_r <= 1'b1;
                    out_r <= shift_r;
                end
            end
            // Execute one cycle after latch, on chip select high
            if (cs_s && pr_s && exec_r)
            begin
                case (cmd)
                    `DRSCU_CMD_RESTORE:
                        if (ch) wiper1_r <= nv_r[1][9:0]; else wiper0_r <= nv_r[0][9:0];
                    `DRSCU_CMD_RESTORE_ALL:
                    begin
                        wiper0_r <= nv_r[0][9:0];
                        wiper1_r <= nv_r[1][9:0];
                    end
                    `DRSCU_CMD_STORE_WIPER, `DRSCU_CMD_STORE_ANY:
                        if (wr_ok)
                        begin
                            if (cmd == `DRSCU_CMD_STORE_WIPER || adr < `DRSCU_USER_LO)
                                nv_r[{3'h0, ch}] <= {6'h00, wsel};
                            else if (adr <= `DRSCU_USER_HI)
                                nv_r[adr] <= last_r[15:0];
                            busy_r <= 1'b1;
                            busy_cnt_r <= 32'h0;
                            ready_oe <= 1'b1;
                        end
                    `DRSCU_CMD_READ_NV:
                        out_r <= {8'h00, nv_r[adr]};
                    `DRSCU_CMD_READ_WIPER:
                        out_r <= {14'h0000, wsel};
                    `DRSCU_CMD_WRITE_WIPER:
                        if (wr_ok && adr[3:1] == 3'b000)
                        begin
                            if (ch) wiper1_r <= wdat; else wiper0_r <= wdat;
                        end
                    `DRSCU_CMD_DEC6, `DRSCU_CMD_INC6, `DRSCU_CMD_DEC1, `DRSCU_CMD_INC1:
                        if (wr_ok)
                        begin
                            if (ch) wiper1_r <= adj(wiper1_r, {cmd[1], cmd[3]});
                            else wiper0_r <= adj(wiper0_r, {cmd[1], cmd[3]});
                        end
                    `DRSCU_CMD_DEC6_ALL, `DRSCU_CMD_INC6_ALL, `DRSCU_CMD_DEC1_ALL, `DRSCU_CMD_INC1_ALL:
                        if (wr_ok)
                        begin
                            wiper0_r <= adj(wiper0_r, {cmd[1], cmd[3]});
                            wiper1_r <= adj(wiper1_r, {cmd[1], cmd[3]});
                        end
                    default:
                        wiper0_r <= wiper0_r;
                endcase
            end
        end
    end

    // Execute strobe follows a valid frame end (or a bare repeat pulse)
    always @(posedge aclk)
    begin
        if (!aresetn)
            exec_r <= 1'b0;
        else
            exec_r <= word_end && (bitcnt_r != 6'h00 || have_last_r);
    end

    // ****************************************
    // AXI4-Lite slave
    // ****************************************
    // Software lock: bit 0 of control blocks writes like the pin
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
            sw_lock_r <= 1'b0;
        end
        else
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            if (s_axi_awready)
                s_axi_bvalid <= 1'b1; // Answer only after both handshakes
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready)
            begin
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
                s_axi_bresp <= 2'b00;
                if (s_axi_awaddr == REG_CTRL)
                begin
                    if (s_axi_wstrb[0])
                        sw_lock_r <= s_axi_wdata[0];
                end
                else
                    s_axi_bresp <= 2'b10;
            end
        end
    end

    // Read path: wipers, status, control
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'b00;
        end
        else
        begin
            s_axi_arready <= 1'b0;
            if (s_axi_arready)
                s_axi_rvalid <= 1'b1; // Data follows the address handshake
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
            if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready)
            begin
                s_axi_arready <= 1'b1;
                s_axi_rresp <= 2'b00;
                case (s_axi_araddr)
                    REG_WIPER0: s_axi_rdata <= {22'h000000, wiper0_r};
                    REG_WIPER1: s_axi_rdata <= {22'h000000, wiper1_r};
                    REG_STATUS: s_axi_rdata <= {30'h00000000, wp_s, busy_r};
                    REG_CTRL: s_axi_rdata <= {31'h00000000, sw_lock_r};
                    default:
                    begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= 2'b10;
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// >>> verif/drscu_monitor.sv
// Checker of the serial command unit, bound to its top module.
// Assumes the bench shortens the store time through STORE_CYCLES.
`timescale 1ns/100ps
`default_nettype none
module drscu_monitor #(
    parameter STORE_CYCLES = 20
)
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus answers
    input wire logic s_axi_arvalid,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // Link and control pins
    input wire logic chip_select_n,
    input wire logic serial_out_oe,
    input wire logic serial_out,
    input wire logic preset_strobe_n,
    input wire logic ready_oe,
    input wire logic [9:0] wiper0_r,
    input wire logic [9:0] wiper1_r
);
    logic [31:0] busy_cnt_r;
    // ******
    // Assertions
    // ******
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Busy length, so a short store shows up
    always_ff @(posedge aclk)
        busy_cnt_r <= (aresetn && ready_oe) ? busy_cnt_r + 32'h1 : 32'h0;
    // Frame open with preset released: nothing may execute yet
    sequence open_frame;
        (!chip_select_n && preset_strobe_n)[*6];
    endsequence
    sequence store_run;
        ready_oe && $past(ready_oe) && preset_strobe_n;
    endsequence
    store_len_a: assert property ($fell(ready_oe) |-> busy_cnt_r >= STORE_CYCLES)
        else $error("store ended early");
    store_lock_a: assert property (store_run |-> $stable(wiper0_r) && $stable(wiper1_r))
        else $error("wiper moved during store");
    preset_mid_a: assert property ((!preset_strobe_n)[*6] |-> wiper0_r == 10'h200 && wiper1_r == 10'h200)
        else $error("preset low without midscale");
    frame_hold_a: assert property (open_frame |-> $stable(wiper0_r) && $stable(wiper1_r))
        else $error("wiper moved with select low");
    out_idle_a: assert property (chip_select_n[*4] |-> !serial_out_oe)
        else $error("serial out driven while deselected");
    out_level_a: assert property (serial_out_oe |-> !serial_out)
        else $error("serial out driven but level high");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    read_answer_a: assert property (s_axi_arvalid && !s_axi_rvalid |-> ##[1:3] s_axi_rvalid)
        else $error("read not answered");
endmodule
bind drscu_top drscu_monitor #(.STORE_CYCLES(STORE_CYCLES)) mon_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .chip_select_n(chip_select_n), .serial_out_oe(serial_out_oe),
    .serial_out(serial_out),
    .preset_strobe_n(preset_strobe_n), .ready_oe(ready_oe), .wiper0_r(wiper0_r), .wiper1_r(wiper1_r));
`default_nettype wire

// >>> verif/drscu_spi_host.sv
// Serial host model that sends command frames.
// Assumes the bench clock; four of its cycles make half a link clock.
`timescale 1ns/100ps
`default_nettype none
module drscu_spi_host (
    // Bench clock
    input wire logic aclk,
    // Link pins
    output logic serial_clk,
    output logic chip_select_n,
    output logic serial_in,
    input wire logic serial_out_oe
);
    // ******
    // Frame driver
    // ******
    // Link clock rests low between frames
    initial
    begin
        serial_clk = 1'h0;
        chip_select_n = 1'h1;
        serial_in = 1'h0;
    end
    task half;
        repeat (4) @(posedge aclk);
    endtask
    // Shifts n bits; close raises select so the word executes
    task xfer(input logic [23:0] w, input int n, input logic close, output logic [23:0] rx);
        int i;
        begin
            rx = 24'h0;
            chip_select_n <= 1'h0;
            half;
            for (i = 0; i < n; i++)
            begin
                serial_in <= w[23 - i];
                half;
                serial_clk <= 1'h1;
                half;
                rx = {rx[22:0], ~serial_out_oe}; // Pull-up reads 1; output trails each fall by 4 cycles
                serial_clk <= 1'h0;
            end
            half;
            serial_in <= ~serial_in; // Inverted line, so no stale level lingers
            if (close)
            begin
                chip_select_n <= 1'h1;
                repeat (2) half;
            end
        end
    endtask
endmodule
`default_nettype wire

// >>> verif/tb_dual_resistor_serial_command_unit.sv
// Self-checking bench for the serial command unit.
// Assumes a short store time and the host model on the link.
`timescale 1ns/100ps
`default_nettype none
module tb_dual_resistor_serial_command_unit;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, preset_n, wp_n;
    logic awready, wready, bvalid, arready, rvalid, sclk, cs_n, sdi, sdo, sdo_oe, ready_oe;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    logic [9:0] wiper0_r, wiper1_r;
    logic [23:0] rx;
    int n_errors = 0;
    int samples_checked = 0;
    // ******
    // Design and host
    // ******
    drscu_top #(.STORE_CYCLES(400)) dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .serial_clk(sclk), .chip_select_n(cs_n), .serial_in(sdi), .serial_out(sdo),
        .serial_out_oe(sdo_oe), .preset_strobe_n(preset_n), .write_protect_n(wp_n),
        .ready_oe(ready_oe), .wiper0_r(wiper0_r), .wiper1_r(wiper1_r));
    drscu_spi_host host_u (.aclk(aclk), .serial_clk(sclk), .chip_select_n(cs_n), .serial_in(sdi),
        .serial_out_oe(sdo_oe));
    initial
    begin
        aclk = 1'h0;
        forever #12.5 aclk = ~aclk;
    end
    // ******
    // Shared tasks
    // ******
    task end_of_test;
        if (n_errors == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task timeout;
        n_errors++;
        $display("BAD %0t wait ran out", $time);
        end_of_test;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [23:0] w);
        host_u.xfer(w, 24, 1'h1, rx);
    endtask
    task wait_ready;
        int k;
        for (k = 0; k < 1000 && ready_oe !== 1'h0; k++)
            @(posedge aclk);
        if (ready_oe !== 1'h0)
            timeout;
    endtask
    // Address and data offered together, each dropped once taken
    task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int k;
        logic got;
        begin
            got = 1'h0;
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'h1;
            wvalid <= 1'h1;
            bready <= 1'h1;
            for (k = 0; k < 50 && !got; k++)
            begin
                @(posedge aclk);
                if (awready)
                    awvalid <= 1'h0;
                if (wready)
                    wvalid <= 1'h0;
                if (bvalid === 1'h1)
                begin
                    r = bresp;
                    got = 1'h1;
                    bready <= 1'h0;
                end
            end
            if (!got)
                timeout;
            @(posedge aclk);
        end
    endtask
    task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int k;
        logic got;
        begin
            got = 1'h0;
            araddr <= a;
            arvalid <= 1'h1;
            rready <= 1'h1;
            for (k = 0; k < 50 && !got; k++)
            begin
                @(posedge aclk);
                if (arready)
                    arvalid <= 1'h0;
                if (rvalid === 1'h1)
                begin
                    d = rdata;
                    r = rresp;
                    got = 1'h1;
                    rready <= 1'h0;
                end
            end
            if (!got)
                timeout;
            @(posedge aclk);
        end
    endtask
    // Halve, double, or step, pinned at both ends
    function logic [9:0] adj(input logic [3:0] c, input logic [9:0] v);
        if (c[1] == 1'h0)
            adj = c[3] ? (v > 10'h1FF ? 10'h3FF : {v[8:0], 1'h0}) : v >> 1;
        else
            adj = c[3] ? (v == 10'h3FF ? v : v + 10'h1) : (v == 10'h0 ? v : v - 10'h1);
    endfunction
    // ******
    // Scenarios
    // ******
    task t_regs;
        logic [31:0] d;
        logic [1:0] r;
        begin
            axi_rd(8'h00, d, r);
            chk(d, 32'h200);
            axi_wr(8'h0C, 32'h1, r);
            chk(r, 2'h0);
            axi_rd(8'h0C, d, r);
            chk(d, 32'h1);
            axi_wr(8'h0C, 32'h0, r);
            axi_wr(8'h00, 32'h5, r);
            chk(r, 2'h2);
            axi_rd(8'h10, d, r);
            chk(r, 2'h2);
        end
    endtask
    task t_write;
        host_u.xfer(24'hB00100, 24, 1'h0, rx);
        chk(wiper0_r, 10'h200);
        host_u.xfer(24'h0, 0, 1'h1, rx);
        chk(wiper0_r, 10'h100);
        chk(wiper1_r, 10'h200);
        wr(24'hB1FFFF);
        chk(wiper1_r, 10'h3FF);
    endtask
    task t_adjust;
        logic [9:0] s;
        int i, j;
        for (j = 0; j < 3; j++)
            for (i = 4; i < 16; i++)
                if (i[2])
                begin
                    s = j == 0 ? 10'h3FF : (j == 1 ? 10'h000 : 10'h155);
                    wr({8'hB0, 6'h00, s});
                    wr({8'hB1, 6'h00, s});
                    wr({i[3:0], 20'h10000});
                    chk(wiper1_r, adj(i[3:0], s));
                    chk(wiper0_r, i[0] ? adj(i[3:0], s) : s);
                end
    endtask
    task t_store;
        logic [31:0] d;
        logic [1:0] r;
        begin
            wr(24'hB000A5);
            wr(24'h200000);
            axi_rd(8'h08, d, r);
            chk(d[0], 1'h1);
            wr(24'hB00011);
            wait_ready;
            chk(wiper0_r, 10'h0A5);
            wr(24'hB00000);
            wr(24'h100000);
            chk(wiper0_r, 10'h0A5);
            wr(24'hB00000);
            wr(24'hB10000);
            wr(24'h800000);
            chk(wiper0_r, 10'h0A5);
            chk(wiper1_r, 10'h200);
            wr(24'h3EBEEF);
            wait_ready;
            wr(24'h9E0000);
            wr(24'hA00000);
            chk(rx, 24'h00BEEF);
            wr(24'h012345);
            chk(rx, 24'h0000A5);
            wr(24'h000000);
            chk(rx, 24'h012345);
        end
    endtask
    task t_pins;
        wr(24'hB10011);
        preset_n <= 1'h0;
        repeat (8) @(posedge aclk);
        chk({wiper0_r, wiper1_r}, 20'h80200);
        preset_n <= 1'h1;
        repeat (8) @(posedge aclk);
        chk({wiper0_r, wiper1_r}, 20'h29600);
        wr(24'hB00033);
        wp_n <= 1'h0;
        wr(24'hB00044);
        wr(24'hE00000);
        chk(wiper0_r, 10'h033);
        wr(24'h100000);
        chk(wiper0_r, 10'h0A5);
        wp_n <= 1'h1;
    endtask
    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
        {preset_n, wp_n, awaddr, araddr, wdata} = 50'h3_0000_0000_0000;
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (4) @(posedge aclk);
        t_regs;
        t_write;
        t_adjust;
        t_store;
        t_pins;
        end_of_test;
    end
    initial
    begin
        repeat (90000) @(posedge aclk);
        timeout;
    end
endmodule
`default_nettype wire
